// *** verilog/fcpwm_top.sv ***
/*
 * four channel pulse width modulator: shared 10-bit down counter,
 * holding and working registers, transfer handshake, pin gating,
 * avalon-mm register slave and a level interrupt.
 * assumes inputs synchronous to i_mclk and an avalon master that
 * holds each request until waitrequest is seen low.
 */
module fcpwm_top
    import fcpwm_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_nrst,
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    output logic      [NUM_CH-1:0] o_pwm_level,
    output logic      [NUM_CH-1:0] o_pwm_pin,
    output logic                   o_irq
);

    logic                  rst_meta_reg;
    logic                  rst_n;
    logic                  ack_reg;
    logic [31:0]           rdata_reg;
    logic [7:0]            rd_mux;
    logic [7:0]            cmp_lo_reg [NUM_CH];
    logic [7:0]            cmp_hi_reg;
    logic [7:0]            per_lo_reg;
    logic [1:0]            per_hi_reg;
    logic [7:0]            ctrl_reg;
    logic [7:0]            ctrl_next;
    logic [7:0]            cfg_reg;
    logic [3:0]            port_reg;
    logic [1:0]            irq_stat_reg;
    logic [1:0]            irq_stat_next;
    logic [1:0]            irq_mask_reg;
    logic [CNT_W-1:0]      cnt_reg;
    logic [CNT_W-1:0]      cnt_next;
    logic [CNT_W-1:0]      per_work_reg;
    logic [CNT_W-1:0]      cmp_work_reg [NUM_CH];
    logic                  div_reg;
    fcpwm_state_type       st_reg;
    fcpwm_state_type       st_next;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // bus decode; one wait state so read data can come from a flop
    wire [7:0]  idx      = i_avs_address[ADDR_W-1:2];
    wire        req      = i_avs_read | i_avs_write;
    wire        wr_take  = i_avs_write & ack_reg & i_avs_byteenable[0];
    wire [7:0]  wbyte    = i_avs_writedata[7:0];
    wire        wr_ctrl  = wr_take & (idx == IDX_CTRL);
    wire        wr_stat  = wr_take & (idx == IDX_IRQ_STAT);

    assign o_avs_waitrequest = req & ~ack_reg;

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            ack_reg <= 1'b0;
        else
            ack_reg <= req & ~ack_reg;
    end

    // configuration and port bits
    wire        full_rate = cfg_reg[CFG_FULL_RATE_BIT];
    wire        port_reset_high      = cfg_reg[CFG_PORT_RESET_HIGH_BIT];
    wire        run       = ctrl_reg[CTRL_RUN_BIT];
    wire        xfer      = ctrl_reg[CTRL_XFER_BIT];
    wire [3:0]  invert    = {ctrl_reg[CTRL_INV3_BIT], ctrl_reg[CTRL_INV2_BIT],
                             ctrl_reg[CTRL_INV1_BIT], ctrl_reg[CTRL_INV0_BIT]};

    // counter timing
    wire        running   = (st_reg == FCPWM_ST_RUN) & run;
    wire        tick      = running & (full_rate | div_reg);
    wire        underflow = tick & (cnt_reg == CNT_ZERO);
    wire        do_xfer   = underflow & xfer;
    wire [9:0]  per_hold  = {per_hi_reg, per_lo_reg};

    assign st_next = run ? FCPWM_ST_RUN : FCPWM_ST_IDLE;

    // reload uses fresh holding value when a copy happens at this underflow
    assign cnt_next = underflow ? (do_xfer ? per_hold : per_work_reg)
                    : tick      ? cnt_reg - CNT_ONE
                    : cnt_reg;

    // set by software wins over the hardware clear of transfer
    assign ctrl_next = wr_ctrl ? (wbyte & CTRL_MASK)
                     : do_xfer ? (ctrl_reg & ~(8'h01 << CTRL_XFER_BIT))
                     : ctrl_reg;

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg  <= FCPWM_ST_IDLE;
            cnt_reg <= CNT_ZERO;
            div_reg <= 1'b0;
        end
        else
        begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
            div_reg <= running ? ~div_reg : 1'b0;
        end
    end

    // holding registers; only written by software, except the transfer bit of ctrl_reg that do_xfer clears
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_CH; i++)
                cmp_lo_reg[i] <= SHADOW_RESET;
            cmp_hi_reg <= SHADOW_RESET;
            per_lo_reg <= SHADOW_RESET;
            per_hi_reg <= PER_HI_RESET;
            ctrl_reg   <= CTRL_RESET;
            cfg_reg    <= CFG_RESET;
            port_reg   <= PORT_RESET;
            irq_mask_reg <= IRQ_RESET;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
                if (wr_take && idx == IDX_CMP0_LO + 8'(i))
                    cmp_lo_reg[i] <= wbyte;
            if (wr_take && idx == IDX_CMP_HI)
                cmp_hi_reg <= wbyte;
            if (wr_take && idx == IDX_PER_LO)
                per_lo_reg <= wbyte;
            if (wr_take && idx == IDX_PER_HI)
                per_hi_reg <= wbyte[1:0];
            if (wr_take && idx == IDX_CFG)
                cfg_reg <= wbyte & CFG_MASK;
            if (wr_take && idx == IDX_PORT)
                port_reg <= wbyte[3:0];
            if (wr_take && idx == IDX_IRQ_MASK)
                irq_mask_reg <= wbyte[1:0];
            ctrl_reg <= ctrl_next;
        end
    end

    // working registers; change only at an underflow with transfer pending
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            per_work_reg <= WORK_RESET;
            for (int i = 0; i < NUM_CH; i++)
                cmp_work_reg[i] <= WORK_RESET;
        end
        else if (do_xfer)
        begin
            per_work_reg <= per_hold;
            for (int i = 0; i < NUM_CH; i++)
                cmp_work_reg[i] <= {cmp_hi_reg[2*i+1], cmp_hi_reg[2*i], cmp_lo_reg[i]};
        end
    end

    // channels
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        fcpwm_channel u_ch (
            .i_mclk    (i_mclk),
            .i_rst_n   (rst_n),
            .i_run     (running),
            .i_count   (cnt_reg),
            .i_period  (per_work_reg),
            .i_compare (cmp_work_reg[g]),
            .i_invert  (invert[g]),
            .o_level   (o_pwm_level[g])
        );
    end

    // pin shows the level only where allowed; limitation: no open-drain modes
    assign o_pwm_pin = o_pwm_level & (port_reg | {NUM_CH{port_reset_high}});

    // sticky events, write one to clear, a new event wins over the clear
    wire [1:0] irq_events = {do_xfer, underflow};
    wire [1:0] irq_w1c    = wr_stat ? wbyte[1:0] : 2'b00;

    assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_events;

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            irq_stat_reg <= IRQ_RESET;
        else
            irq_stat_reg <= irq_stat_next;
    end

    assign o_irq = |(irq_stat_reg & irq_mask_reg);

    // read path
    always_comb
    begin
        rd_mux = 8'h00;
        case (idx)
            IDX_CMP0_LO:  rd_mux = cmp_lo_reg[0];
            IDX_CMP1_LO:  rd_mux = cmp_lo_reg[1];
            IDX_CMP2_LO:  rd_mux = cmp_lo_reg[2];
            IDX_CMP3_LO:  rd_mux = cmp_lo_reg[3];
            IDX_CMP_HI:   rd_mux = cmp_hi_reg;
            IDX_PER_LO:   rd_mux = per_lo_reg;
            IDX_PER_HI:   rd_mux = {6'h00, per_hi_reg};
            IDX_CTRL:     rd_mux = ctrl_reg;
            IDX_CFG:      rd_mux = cfg_reg;
            IDX_PORT:     rd_mux = {4'h0, port_reg};
            IDX_IRQ_STAT: rd_mux = {6'h00, irq_stat_reg};
            IDX_IRQ_MASK: rd_mux = {6'h00, irq_mask_reg};
            default:      rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= 32'h0000_0000;
        else if (i_avs_read && !ack_reg)
            rdata_reg <= {24'h00_0000, rd_mux};
    end

    assign o_avs_readdata = rdata_reg;

    // checks
    property p_reset_high;
        @(posedge i_mclk) $rose(rst_n) |-> (o_pwm_level == 4'hf);
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("outputs not high after reset");

    property p_pin_gate;
        @(posedge i_mclk) disable iff (!rst_n)
        (!port_reset_high && port_reg == 4'h0) |-> (o_pwm_pin == 4'h0);
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("pin shows level while gated");

    property p_reload;
        @(posedge i_mclk) disable iff (!rst_n)
        (underflow && !xfer) |=> (cnt_reg == $past(per_work_reg));
    endproperty
    a_reload: assert property (p_reload) else $error("counter not reloaded on underflow");

    property p_half_rate;
        @(posedge i_mclk) disable iff (!rst_n)
        (tick && !full_rate && !(wr_take && idx == IDX_CFG)) |=> !tick;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("half rate counter ticked twice");

    property p_copy;
        @(posedge i_mclk) disable iff (!rst_n)
        do_xfer |=> (per_work_reg == $past(per_hold)) && (xfer == $past(wr_ctrl && wbyte[CTRL_XFER_BIT]));
    endproperty
    a_copy: assert property (p_copy) else $error("transfer copy or clear wrong");

    property p_no_copy_idle;
        @(posedge i_mclk) disable iff (!rst_n)
        !running |=> $stable(per_work_reg) && $stable(cmp_work_reg[0]);
    endproperty
    a_no_copy_idle: assert property (p_no_copy_idle) else $error("copy while not running");

    property p_cancel;
        @(posedge i_mclk) disable iff (!rst_n)
        (wr_ctrl && !wbyte[CTRL_XFER_BIT]) |=> !xfer ##1 $stable(per_work_reg);
    endproperty
    a_cancel: assert property (p_cancel) else $error("pending copy not cancelled");

    property p_freeze;
        @(posedge i_mclk) disable iff (!rst_n)
        !run |=> $stable(o_pwm_level);
    endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while stopped");

    property p_start_high;
        @(posedge i_mclk) disable iff (!rst_n)
        (underflow && !xfer && !invert[0] && cmp_work_reg[0] <= per_work_reg
         && cmp_work_reg[0] != CMP_ALL_ONES && full_rate && run && !wr_ctrl)
        |=> run [*2] ##0 o_pwm_level[0];
    endproperty
    a_start_high: assert property (p_start_high) else $error("channel not high after underflow");

    property p_all_ones_low;
        @(posedge i_mclk) disable iff (!rst_n)
        (running && cmp_work_reg[2] == CMP_ALL_ONES && !invert[2]) |=> !o_pwm_level[2];
    endproperty
    a_all_ones_low: assert property (p_all_ones_low) else $error("all ones compare not low");

    property p_above_high;
        @(posedge i_mclk) disable iff (!rst_n)
        (running && cmp_work_reg[3] > per_work_reg && cmp_work_reg[3] != CMP_ALL_ONES
         && !invert[3]) |=> o_pwm_level[3];
    endproperty
    a_above_high: assert property (p_above_high) else $error("compare above period not high");

    c_transfer:  cover property (@(posedge i_mclk) disable iff (!rst_n) do_xfer);
    c_irq:       cover property (@(posedge i_mclk) disable iff (!rst_n) $rose(o_irq));
    c_stop:      cover property (@(posedge i_mclk) disable iff (!rst_n) $fell(run));
    c_half_uflw: cover property (@(posedge i_mclk) disable iff (!rst_n) underflow && !full_rate);

endmodule : fcpwm_top

// *** pkg/fcpwm_pkg.sv ***
/*
 * constants, register indices, field positions and types for the
 * four channel pulse width modulator.
 * assumes a single clock domain and a 32-bit avalon-mm register bus.
 */
package fcpwm_pkg;

    localparam int unsigned NUM_CH        = 4;
    localparam int unsigned CNT_W         = 10;
    localparam int unsigned ADDR_W        = 10;

    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CMP0_LO   = 8'hd3;
    localparam logic [7:0]  IDX_CMP1_LO   = 8'hd4;
    localparam logic [7:0]  IDX_CMP2_LO   = 8'hd5;
    localparam logic [7:0]  IDX_CMP3_LO   = 8'hd6;
    localparam logic [7:0]  IDX_CMP_HI    = 8'hd7;
    localparam logic [7:0]  IDX_PER_LO    = 8'hd8;
    localparam logic [7:0]  IDX_PER_HI    = 8'hd9;
    localparam logic [7:0]  IDX_CTRL      = 8'hda;
    localparam logic [7:0]  IDX_CFG       = 8'he0;
    localparam logic [7:0]  IDX_PORT      = 8'he1;
    localparam logic [7:0]  IDX_IRQ_STAT  = 8'he2;
    localparam logic [7:0]  IDX_IRQ_MASK  = 8'he3;

    // modulator_control fields
    localparam int unsigned CTRL_RUN_BIT  = 7;
    localparam int unsigned CTRL_XFER_BIT = 6;
    localparam int unsigned CTRL_INV3_BIT = 5;
    localparam int unsigned CTRL_INV2_BIT = 4;
    localparam int unsigned CTRL_INV1_BIT = 2;
    localparam int unsigned CTRL_INV0_BIT = 1;
    localparam logic [7:0]  CTRL_MASK     = 8'hf6;

    // user_config_byte fields
    localparam int unsigned CFG_FULL_RATE_BIT = 3;
    localparam int unsigned CFG_PORT_RESET_HIGH_BIT      = 5;
    localparam logic [7:0]  CFG_MASK          = 8'h28;

    // interrupt status / mask fields
    localparam int unsigned IRQ_UNDERFLOW_BIT = 0;
    localparam int unsigned IRQ_XFER_BIT      = 1;

    // reset values
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  CFG_RESET     = 8'h28;
    localparam logic [7:0]  SHADOW_RESET  = 8'h00;
    localparam logic [1:0]  PER_HI_RESET  = 2'h0;
    localparam logic [3:0]  PORT_RESET    = 4'h0;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;
    localparam logic [9:0]  WORK_RESET    = 10'h000;
    localparam logic        PWM_RESET     = 1'b1;

    localparam logic [9:0]  CMP_ALL_ONES  = 10'h3ff;
    localparam logic [9:0]  CNT_ZERO      = 10'h000;
    localparam logic [9:0]  CNT_ONE       = 10'h001;

    typedef enum logic [1:0] {
        FCPWM_ST_IDLE = 2'b01,
        FCPWM_ST_RUN  = 2'b10
    } fcpwm_state_type;

endpackage : fcpwm_pkg

// *** verilog/fcpwm_channel.sv ***
/*
 * one modulator channel: compares the shared counter with its working
 * compare value and holds the output level in a flip-flop.
 * assumes counter, period and compare come from the same clock domain.
 */
module fcpwm_channel
    import fcpwm_pkg::*;
(
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic             i_run,
    input  wire logic [CNT_W-1:0] i_count,
    input  wire logic [CNT_W-1:0] i_period,
    input  wire logic [CNT_W-1:0] i_compare,
    input  wire logic             i_invert,
    output logic                  o_level
);

    logic level_reg;
    logic level_next;
    logic raw_level;

    function automatic logic fcpwm_raw(input logic [CNT_W-1:0] cnt,
                                       input logic [CNT_W-1:0] per,
                                       input logic [CNT_W-1:0] cmp);
        logic r;
        if (cmp == CMP_ALL_ONES)
            r = 1'b0;
        else if (cmp > per)
            r = 1'b1;
        else
            r = (cnt >= cmp);
        return r;
    endfunction : fcpwm_raw

    assign raw_level  = fcpwm_raw(i_count, i_period, i_compare);
    assign level_next = i_run ? (raw_level ^ i_invert) : level_reg;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            level_reg <= PWM_RESET;
        else
            level_reg <= level_next;
    end

    assign o_level = level_reg;

endmodule : fcpwm_channel

// *** test/fcpwm_load_model.sv ***
/*
 * passive loads on the four modulator pins: length of each finished
 * high and low run in mclk cycles, and an edge count per pin.
 * assumes pins settle between rising edges of i_mclk; loads never drive back.
 */
module fcpwm_load_model
    import fcpwm_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic [NUM_CH-1:0] i_pin,
    output logic      [15:0]       o_high_len [NUM_CH],
    output logic      [15:0]       o_low_len  [NUM_CH],
    output logic      [15:0]       o_edges    [NUM_CH]
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [NUM_CH-1:0] prev_reg;
    logic [15:0]       run_reg [NUM_CH];

    initial
    begin
        prev_reg = '1;
        for (int i = 0; i < NUM_CH; i++)
        begin
            run_reg[i]    = 16'h0000;
            o_high_len[i] = 16'h0000;
            o_low_len[i]  = 16'h0000;
            o_edges[i]    = 16'h0000;
        end
    end

    // a run is reported only when it ends, so a stuck pin keeps its old figure
    always @(posedge i_mclk)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (i_pin[i] !== prev_reg[i])
            begin
                if (prev_reg[i])
                    o_high_len[i] <= run_reg[i];
                else
                    o_low_len[i] <= run_reg[i];
                o_edges[i] <= o_edges[i] + 16'h0001;
                run_reg[i] <= 16'h0001;
            end
            else
                run_reg[i] <= run_reg[i] + 16'h0001;
        end
        prev_reg <= i_pin;
    end
endmodule : fcpwm_load_model

// *** test/fcpwm_top_tb.sv ***
/*
 * self-checking bench for the four channel modulator: avalon-mm
 * register tasks, run lengths measured by the pin load model.
 * assumes one wait state is not relied upon; waits are bounded.
 */
module fcpwm_top_tb
    import fcpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int LIMIT = 20000;
    localparam logic [7:0] RIDX [13] = '{IDX_CMP0_LO, IDX_CMP1_LO, IDX_CMP2_LO, IDX_CMP3_LO, IDX_CMP_HI,
        IDX_PER_LO, IDX_PER_HI, IDX_CTRL, IDX_CFG, IDX_PORT, IDX_IRQ_STAT, IDX_IRQ_MASK, 8'hc0};
    localparam logic [7:0] RVAL [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h28,
        8'h00, 8'h00, 8'h00, 8'h00};

    logic              clk;
    logic              nrst;
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic [3:0]        be;
    logic              waitreq;
    logic              irq;
    logic [NUM_CH-1:0] level;
    logic [NUM_CH-1:0] pin;
    logic [15:0]       hi_len [NUM_CH];
    logic [15:0]       lo_len [NUM_CH];
    logic [15:0]       edges  [NUM_CH];
    logic [NUM_CH-1:0] lsnap;
    logic [15:0]       snap;
    logic [7:0]        q;
    int                fails;
    int                compares;
    int                cycles;

    fcpwm_top uut (.i_mclk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .o_pwm_level(level), .o_pwm_pin(pin), .o_irq(irq));

    fcpwm_load_model loads (.i_mclk(clk), .i_pin(pin), .o_high_len(hi_len), .o_low_len(lo_len),
        .o_edges(edges));

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask : ticks

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic is_wr, input logic [7:0] idx, input logic [7:0] d, input logic be0);
        int n;
        @(posedge clk);
        addr  <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        be    <= {3'b111, be0};
        wr    <= is_wr;
        rd    <= ~is_wr;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 50);
        q = rdata[7:0];
        if (n >= 50)
            check(32'h1, 32'h0, "no bus answer");
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 1'b1);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00, 1'b1);
        check(32'(q), 32'(exp), what);
    endtask : rd_chk

    // software side: poll the transfer bit until hardware clears it
    task automatic wait_xfer();
        int n;
        n = 0;
        do
        begin
            bus(1'b0, IDX_CTRL, 8'h00, 1'b1);
            n++;
        end
        while (q[CTRL_XFER_BIT] !== 1'b0 && n < 100);
        check(32'(q[CTRL_XFER_BIT]), 32'h0, "transfer bit stuck");
    endtask : wait_xfer

    // align to a fresh underflow so a short write sequence stays inside one period
    task automatic wait_uflw();
        int n;
        n = 0;
        wr_reg(IDX_IRQ_STAT, 8'h01);
        do
        begin
            bus(1'b0, IDX_IRQ_STAT, 8'h00, 1'b1);
            n++;
        end
        while (q[IRQ_UNDERFLOW_BIT] !== 1'b1 && n < 100);
        check(32'(q[IRQ_UNDERFLOW_BIT]), 32'h1, "no underflow seen");
    endtask : wait_uflw

    // two windows of two periods each; channels 1..3 must not move
    task automatic measure(input int h, input int l, input logic [2:0] still);
        logic [15:0] s;
        ticks(2 * (h + l));
        s = edges[1] + edges[2] + edges[3];
        ticks(2 * (h + l));
        check(32'(hi_len[0]), h, "high run");
        check(32'(lo_len[0]), l, "low run");
        check(32'(16'(edges[1] + edges[2] + edges[3])), 32'(s), "steady channel moved");
        check(32'(level[3:1]), 32'(still), "steady levels");
    endtask : measure

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            $display("CHECK FAILED at %0t: run too long", $time);
            complete_run();
        end
    end

    initial
    begin
        nrst = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        wdata = '0;
        be = 4'hf;
        fails = 0;
        compares = 0;
        cycles = 0;
        ticks(20);
        nrst <= 1'b1;
        ticks(3);
        check(32'(level), 32'h0000000f, "levels after reset");
        check(32'(pin), 32'h0000000f, "pins after reset");
        bus(1'b1, IDX_CMP0_LO, 8'h55, 1'b0);
        wr_reg(8'hc0, 8'hff);
        for (int i = 0; i < 13; i++)
            rd_chk(RIDX[i], RVAL[i], "reset value");
        wr_reg(IDX_CFG, 8'h08);
        ticks(1);
        check(32'(pin), 32'h0, "pins hidden");
        wr_reg(IDX_PORT, 8'h01);
        ticks(1);
        check(32'(pin), 32'h1, "pin 0 shown");
        wr_reg(IDX_PORT, 8'h0f);
        wr_reg(IDX_CMP0_LO, 8'h05);
        wr_reg(IDX_CMP2_LO, 8'hff);
        wr_reg(IDX_CMP3_LO, 8'h15);
        wr_reg(IDX_CMP_HI, 8'h30);
        wr_reg(IDX_PER_LO, 8'h14);
        wr_reg(IDX_IRQ_MASK, 8'h02);
        rd_chk(IDX_CMP_HI, 8'h30, "compare upper");
        ticks(30);
        check(32'(level), 32'h0000000f, "holding only");
        wr_reg(IDX_CTRL, 8'hc0);
        wait_xfer();
        ticks(1);
        check(32'(irq), 32'h1, "transfer irq");
        wr_reg(IDX_IRQ_STAT, 8'h02);
        ticks(1);
        check(32'(irq), 32'h0, "irq cleared");
        rd_chk(IDX_IRQ_STAT, 8'h01, "underflow status");
        wr_reg(IDX_IRQ_MASK, 8'h01);
        ticks(1);
        check(32'(irq), 32'h1, "underflow irq");
        wr_reg(IDX_IRQ_MASK, 8'h00);
        ticks(1);
        check(32'(irq), 32'h0, "irq masked");
        measure(16, 5, 3'b101);
        wr_reg(IDX_CFG, 8'h00);
        measure(32, 10, 3'b101);
        wr_reg(IDX_CFG, 8'h08);
        wr_reg(IDX_CTRL, 8'hf6);
        wait_xfer();
        measure(5, 16, 3'b010);
        wr_reg(IDX_CTRL, 8'hc0);
        wait_xfer();
        // both control writes must land inside one 21-cycle period
        wr_reg(IDX_CMP0_LO, 8'h0a);
        wait_uflw();
        wr_reg(IDX_CTRL, 8'hc0);
        wr_reg(IDX_CTRL, 8'h80);
        rd_chk(IDX_CTRL, 8'h80, "copy cancelled");
        measure(16, 5, 3'b101);
        wr_reg(IDX_CTRL, 8'h00);
        ticks(1);
        lsnap = level;
        snap = edges[0] + edges[1] + edges[2] + edges[3];
        ticks(100);
        check(32'(level), 32'(lsnap), "frozen level");
        check(32'(16'(edges[0] + edges[1] + edges[2] + edges[3])), 32'(snap), "frozen pins");
        wr_reg(IDX_CTRL, 8'h40);
        ticks(60);
        rd_chk(IDX_CTRL, 8'h40, "no copy while stopped");
        check(32'(level), 32'(lsnap), "still frozen");
        wr_reg(IDX_CTRL, 8'h80);
        measure(16, 5, 3'b101);
        wr_reg(IDX_CTRL, 8'hc0);
        wait_xfer();
        measure(11, 10, 3'b101);
        wr_reg(IDX_CTRL, 8'h09);
        rd_chk(IDX_CTRL, 8'h00, "reserved control bits");
        complete_run();
    end
endmodule : fcpwm_top_tb
